// ===== common/sbw_pkg.sv
// constants, types and field layout of the spi buffer status / wake block
package sbw_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_BUFCTL = 8'h38;
    localparam logic [7:0] OFF_BUFSTS = 8'h3c;
    localparam logic [7:0] OFF_WKCTL = 8'h54;
    localparam logic [7:0] OFF_WKSTS = 8'h58;
    localparam logic [7:0] OFF_IRQMSK = 8'h60;
    // status fields
    localparam int B_RX_BUFFER_EMPTY = 0;
    localparam int B_RX_BUFFER_FULL = 1;
    localparam int B_RXOV = 3;
    localparam int B_TX_BUFFER_EMPTY = 8;
    localparam int B_TX_BUFFER_FULL = 9;
    localparam int B_TXUDR = 11;
    // buffer control fields
    localparam int B_UDRIEN = 6;
    localparam int B_OVIEN = 14;
    // wake control and status fields
    localparam int B_WAKE_FUNCTION_ENABLE = 0;
    localparam int B_WKADDR = 1;
    localparam int B_POWERDOWN_BLOCKING_OPTION = 2;
    localparam int B_WKF = 0;
    localparam logic [31:0] RST_BUFSTS = 32'h0000_0101;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        PD_RUN = 3'h1,
        PD_HOLD = 3'h2,
        PD_DOWN = 3'h4
    } sbw_pd_t;
endpackage

// ===== core/sbw_core.sv
// spi buffer status, wake-up control and axi4-lite register slave
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module sbw_core import sbw_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic tx_buffer_full,
    input wire logic tx_buffer_empty,
    input wire logic rx_buffer_full,
    input wire logic rx_buffer_empty,
    input wire logic rx_done,
    input wire logic slave_tx_slot,
    input wire logic xfer_active,
    input wire logic pd_request,
    input wire logic data_toggle,
    input wire logic addr_match,
    output logic underrun_irq,
    output logic overrun_irq,
    output logic irq,
    output logic xfer_abort,
    output logic powerdown,
    output logic idle_mode,
    output logic wake_req
);
    // axi write path state
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [ADDR_W-1:0] waddr_q, waddr_d;
    logic [31:0] wdata_q, wdata_d, wmask_q, wmask_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    // axi read path state
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    // register contents
    logic udr_q, udr_d, ov_q, ov_d, wkf_q, wkf_d;
    logic tx_buffer_full_q, tx_buffer_full_d, tx_buffer_empty_q, tx_buffer_empty_d;
    logic rx_buffer_full_q, rx_buffer_full_d, rx_buffer_empty_q, rx_buffer_empty_d;
    logic udr_en_q, udr_en_d, ov_en_q, ov_en_d;
    logic wake_function_enable_q, wake_function_enable_d, wkaddr_q, wkaddr_d, powerdown_blocking_option_q, powerdown_blocking_option_d;
    logic msk_udr_q, msk_udr_d, msk_ov_q, msk_ov_d;
    // outputs and power state
    logic udr_irq_q, udr_irq_d, ov_irq_q, ov_irq_d, irq_q, irq_d;
    logic abort_q, abort_d, wake_q, wake_d;
    sbw_pd_t pd_q, pd_d;

    logic aw_take, w_take, ar_take, wr_fire;
    logic wr_bufctl, wr_bufsts, wr_wkctl, wr_wksts, wr_irqmsk;
    logic [31:0] wbits, wclr, sts_word;
    logic wake_hit, ov_event, udr_event;

    assign aw_take = awvalid && awready_q;
    assign w_take = wvalid && wready_q;
    assign ar_take = arvalid && arready_q;
    // the write lands one cycle after both halves are held
    assign wr_fire = aw_got_q && w_got_q;
    assign wr_bufctl = wr_fire && (waddr_q == OFF_BUFCTL);
    assign wr_bufsts = wr_fire && (waddr_q == OFF_BUFSTS);
    assign wr_wkctl = wr_fire && (waddr_q == OFF_WKCTL);
    assign wr_wksts = wr_fire && (waddr_q == OFF_WKSTS);
    assign wr_irqmsk = wr_fire && (waddr_q == OFF_IRQMSK);
    // merged write value and one-to-clear pattern, lanes honoured
    assign wbits = wdata_q & wmask_q;
    assign wclr = wbits;

    // status word as software sees it
    always_comb begin
        sts_word = RST_ZERO;
        sts_word[B_RX_BUFFER_EMPTY] = rx_buffer_empty_q;
        sts_word[B_RX_BUFFER_FULL] = rx_buffer_full_q;
        sts_word[B_RXOV] = ov_q;
        sts_word[B_TX_BUFFER_EMPTY] = tx_buffer_empty_q;
        sts_word[B_TX_BUFFER_FULL] = tx_buffer_full_q;
        sts_word[B_TXUDR] = udr_q;
    end

    // axi handshake next state; address and data may come in either order
    always_comb begin
        aw_got_d = (aw_got_q || aw_take) && !wr_fire;
        w_got_d = (w_got_q || w_take) && !wr_fire;
        waddr_d = aw_take ? awaddr : waddr_q;
        wdata_d = w_take ? wdata : wdata_q;
        wmask_d = w_take ? {{8{wstrb[3]}}, {8{wstrb[2]}},
                            {8{wstrb[1]}}, {8{wstrb[0]}}} : wmask_q;
        bvalid_d = wr_fire || (bvalid_q && !bready);
        awready_d = !aw_got_d && !bvalid_d;
        wready_d = !w_got_d && !bvalid_d;
        bresp_d = bresp_q;
        if (wr_fire) begin
            bresp_d = (wr_bufctl || wr_bufsts || wr_wkctl || wr_wksts ||
                       wr_irqmsk) ? RESP_OKAY : RESP_SLVERR;
        end
        rvalid_d = ar_take || (rvalid_q && !rready);
        arready_d = !rvalid_d;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (ar_take) begin
            rresp_d = RESP_OKAY;
            rdata_d = RST_ZERO;
            case (araddr)
                OFF_BUFSTS: rdata_d = sts_word;
                OFF_BUFCTL: begin
                    rdata_d[B_UDRIEN] = udr_en_q;
                    rdata_d[B_OVIEN] = ov_en_q;
                end
                OFF_WKCTL: begin
                    rdata_d[B_WAKE_FUNCTION_ENABLE] = wake_function_enable_q;
                    rdata_d[B_WKADDR] = wkaddr_q;
                    rdata_d[B_POWERDOWN_BLOCKING_OPTION] = powerdown_blocking_option_q;
                end
                OFF_WKSTS: rdata_d[B_WKF] = wkf_q;
                OFF_IRQMSK: begin
                    rdata_d[B_TXUDR] = msk_udr_q;
                    rdata_d[B_RXOV] = msk_ov_q;
                end
                default: rresp_d = RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= '0;
            wdata_q <= RST_ZERO;
            wmask_q <= RST_ZERO;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= RST_ZERO;
            rresp_q <= RESP_OKAY;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q <= w_got_d;
            waddr_q <= waddr_d;
            wdata_q <= wdata_d;
            wmask_q <= wmask_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign ov_event = rx_done && rx_buffer_full;
    assign udr_event = slave_tx_slot && tx_buffer_empty;
    assign wake_hit = wkaddr_q ? addr_match : data_toggle;

    // register file and flags next state; a set beats a same-cycle clear
    always_comb begin
        udr_d = udr_event || (udr_q && !(wr_bufsts && wclr[B_TXUDR]));
        ov_d = ov_event || (ov_q && !(wr_bufsts && wclr[B_RXOV]));
        tx_buffer_full_d = tx_buffer_full;
        tx_buffer_empty_d = tx_buffer_empty;
        rx_buffer_full_d = rx_buffer_full;
        rx_buffer_empty_d = rx_buffer_empty;
        udr_en_d = udr_en_q;
        ov_en_d = ov_en_q;
        if (wr_bufctl && wmask_q[B_UDRIEN]) begin
            udr_en_d = wdata_q[B_UDRIEN];
        end
        if (wr_bufctl && wmask_q[B_OVIEN]) begin
            ov_en_d = wdata_q[B_OVIEN];
        end
        wake_function_enable_d = wake_function_enable_q;
        wkaddr_d = wkaddr_q;
        powerdown_blocking_option_d = powerdown_blocking_option_q;
        if (wr_wkctl && wmask_q[B_WAKE_FUNCTION_ENABLE]) begin
            wake_function_enable_d = wdata_q[B_WAKE_FUNCTION_ENABLE];
            wkaddr_d = wdata_q[B_WKADDR];
            powerdown_blocking_option_d = wdata_q[B_POWERDOWN_BLOCKING_OPTION];
        end
        msk_udr_d = msk_udr_q;
        msk_ov_d = msk_ov_q;
        if (wr_irqmsk) begin
            msk_udr_d = wmask_q[B_TXUDR] ? wdata_q[B_TXUDR] : msk_udr_q;
            msk_ov_d = wmask_q[B_RXOV] ? wdata_q[B_RXOV] : msk_ov_q;
        end
    end

    // power-down sequencing; only one request is acted on per state
    always_comb begin
        pd_d = pd_q;
        abort_d = 1'b0;
        wake_d = 1'b0;
        wkf_d = wkf_q && !(wr_wksts && wclr[B_WKF]);
        case (pd_q)
            PD_RUN: begin
                if (pd_request && xfer_active && powerdown_blocking_option_q) begin
                    pd_d = PD_HOLD;
                end else if (pd_request) begin
                    abort_d = xfer_active;
                    pd_d = PD_DOWN;
                end
            end
            PD_HOLD: begin
                if (!xfer_active) begin
                    pd_d = PD_RUN;
                end
            end
            PD_DOWN: begin
                if (wake_function_enable_q && wake_hit) begin
                    wake_d = 1'b1;
                    wkf_d = 1'b1;
                    pd_d = PD_RUN;
                end
            end
            default: pd_d = PD_RUN;
        endcase
        // requests follow flag and enable; mask gates summary line
        udr_irq_d = udr_q && udr_en_q;
        ov_irq_d = ov_q && ov_en_q;
        irq_d = (udr_q && udr_en_q && msk_udr_q) ||
                (ov_q && ov_en_q && msk_ov_q);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // empties read 1 out of reset
            udr_q <= RST_BUFSTS[B_TXUDR];
            ov_q <= RST_BUFSTS[B_RXOV];
            tx_buffer_full_q <= RST_BUFSTS[B_TX_BUFFER_FULL];
            tx_buffer_empty_q <= RST_BUFSTS[B_TX_BUFFER_EMPTY];
            rx_buffer_full_q <= RST_BUFSTS[B_RX_BUFFER_FULL];
            rx_buffer_empty_q <= RST_BUFSTS[B_RX_BUFFER_EMPTY];
            udr_en_q <= 1'b0;
            ov_en_q <= 1'b0;
            wake_function_enable_q <= RST_ZERO[B_WAKE_FUNCTION_ENABLE];
            wkaddr_q <= RST_ZERO[B_WKADDR];
            powerdown_blocking_option_q <= RST_ZERO[B_POWERDOWN_BLOCKING_OPTION];
            wkf_q <= 1'b0;
            msk_udr_q <= 1'b0;
            msk_ov_q <= 1'b0;
            udr_irq_q <= 1'b0;
            ov_irq_q <= 1'b0;
            irq_q <= 1'b0;
            abort_q <= 1'b0;
            wake_q <= 1'b0;
            pd_q <= PD_RUN;
        end else begin
            udr_q <= udr_d;
            ov_q <= ov_d;
            tx_buffer_full_q <= tx_buffer_full_d;
            tx_buffer_empty_q <= tx_buffer_empty_d;
            rx_buffer_full_q <= rx_buffer_full_d;
            rx_buffer_empty_q <= rx_buffer_empty_d;
            udr_en_q <= udr_en_d;
            ov_en_q <= ov_en_d;
            wake_function_enable_q <= wake_function_enable_d;
            wkaddr_q <= wkaddr_d;
            powerdown_blocking_option_q <= powerdown_blocking_option_d;
            wkf_q <= wkf_d;
            msk_udr_q <= msk_udr_d;
            msk_ov_q <= msk_ov_d;
            udr_irq_q <= udr_irq_d;
            ov_irq_q <= ov_irq_d;
            irq_q <= irq_d;
            abort_q <= abort_d;
            wake_q <= wake_d;
            pd_q <= pd_d;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign underrun_irq = udr_irq_q;
    assign overrun_irq = ov_irq_q;
    assign irq = irq_q;
    assign xfer_abort = abort_q;
    assign powerdown = pd_q[2];
    assign idle_mode = pd_q[1];
    assign wake_req = wake_q;

    // checks, all in the aclk domain
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_down_armed;
        pd_q == PD_DOWN && wake_function_enable_q && wake_hit;
    endsequence
    sequence s_woken;
        wake_q && wkf_q && pd_q == PD_RUN;
    endsequence

    property p_udr_set;
        udr_event |=> udr_q;
    endproperty
    a_udr_set: assert property (p_udr_set)
        else $error("underrun flag not set");
    property p_udr_irq;
        udr_q && udr_en_q |=> underrun_irq;
    endproperty
    a_udr_irq: assert property (p_udr_irq)
        else $error("underrun request missing");
    property p_ov_keep;
        ov_q && !wr_bufsts |=> ov_q;
    endproperty
    a_ov_keep: assert property (p_ov_keep)
        else $error("overrun flag lost without clear");
    property p_ov_irq;
        ov_irq_q == $past(ov_q && ov_en_q);
    endproperty
    a_ov_irq: assert property (p_ov_irq)
        else $error("overrun request wrong");
    property p_tx_buffer_full;
        tx_buffer_full |=> sts_word[B_TX_BUFFER_FULL];
    endproperty
    a_tx_buffer_full: assert property (p_tx_buffer_full)
        else $error("tx full not shown");
    property p_rx_buffer_empty;
        !rx_buffer_empty |=> !sts_word[B_RX_BUFFER_EMPTY];
    endproperty
    a_rx_buffer_empty: assert property (p_rx_buffer_empty)
        else $error("rx empty shown while holding data");
    property p_reset_val;
        $rose(aresetn) |-> sts_word == RST_BUFSTS;
    endproperty
    a_reset_val: assert property (p_reset_val)
        else $error("status reset value wrong");
    property p_no_wake;
        pd_q == PD_DOWN && !wake_function_enable_q |=> !wake_req && powerdown;
    endproperty
    a_no_wake: assert property (p_no_wake)
        else $error("woke while wake disabled");
    property p_wake;
        s_down_armed |=> s_woken;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake sequence incomplete");
    property p_abort;
        pd_q == PD_RUN && pd_request && xfer_active && !powerdown_blocking_option_q
            |=> xfer_abort && powerdown ##1 !xfer_abort;
    endproperty
    a_abort: assert property (p_abort)
        else $error("abort into power-down missing");
    property p_hold;
        pd_q == PD_RUN && pd_request && xfer_active && powerdown_blocking_option_q
            |=> idle_mode && !xfer_abort && !powerdown;
    endproperty
    a_hold: assert property (p_hold)
        else $error("blocking option not honoured");
    property p_ov_event;
        ov_event |=> ov_q;
    endproperty
    a_ov_event: assert property (p_ov_event)
        else $error("overrun event missed");
endmodule

// ===== verif/tb_spi_buffer_status_wakeup.sv
// self-checking bench for the spi buffer status and wake-up register block
`timescale 1ns/1ps
module tb_spi_buffer_status_wakeup import sbw_pkg::*; ;
    logic aclk, aresetn;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic tx_buffer_full, tx_buffer_empty, rx_buffer_full, rx_buffer_empty;
    logic rx_done, slave_tx_slot, xfer_active, pd_request;
    logic data_toggle, addr_match;
    logic underrun_irq, overrun_irq, irq, xfer_abort, powerdown;
    logic idle_mode, wake_req;
    int fails, compares, cycles;
    logic [31:0] rd;
    logic [1:0] rs;

    sbw_core uut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .tx_buffer_full(tx_buffer_full), .tx_buffer_empty(tx_buffer_empty),
        .rx_buffer_full(rx_buffer_full), .rx_buffer_empty(rx_buffer_empty),
        .rx_done(rx_done), .slave_tx_slot(slave_tx_slot),
        .xfer_active(xfer_active), .pd_request(pd_request),
        .data_toggle(data_toggle), .addr_match(addr_match),
        .underrun_irq(underrun_irq), .overrun_irq(overrun_irq), .irq(irq),
        .xfer_abort(xfer_abort), .powerdown(powerdown),
        .idle_mode(idle_mode), .wake_req(wake_req)
    );

    // verdict and end of run, reached from the main sequence or the timeout
    task automatic complete_run;
        if (fails == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
            input string msg);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h want %h", $time, msg,
                seen, exp);
        end
    endtask

    task automatic cb(input logic seen, input logic exp, input string msg);
        check({31'h0, seen}, {31'h0, exp}, msg);
    endtask

    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
            input logic [1:0] er);
        logic aw_hit, w_hit, aw_ok, w_ok;
        aw_ok = 1'h0;
        w_ok = 1'h0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        while (!(aw_ok && w_ok)) begin
            @(negedge aclk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            @(posedge aclk);
            if (aw_hit) awvalid <= 1'h0;
            if (w_hit) wvalid <= 1'h0;
            aw_ok = aw_ok || aw_hit;
            w_ok = w_ok || w_hit;
        end
        do @(negedge aclk); while (bvalid !== 1'h1);
        rs = bresp;
        @(posedge aclk);
        bready <= 1'h0;
        check({30'h0, rs}, {30'h0, er}, "write response");
    endtask

    // read: rready held high until the data beat is sampled
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do @(negedge aclk); while (arready !== 1'h1);
        @(posedge aclk);
        arvalid <= 1'h0;
        do @(negedge aclk); while (rvalid !== 1'h1);
        rd = rdata;
        rs = rresp;
        @(posedge aclk);
        rready <= 1'h0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
            input string msg);
        rd_reg(a);
        check(rd, exp, msg);
    endtask

    // one cycle of the power-side inputs, then let that edge settle
    task automatic step(input logic [3:0] v);
        @(posedge aclk);
        {pd_request, data_toggle, addr_match, xfer_active} <= v;
        #1;
    endtask

    task automatic t_reset;
        rchk(OFF_BUFSTS, RST_BUFSTS, "status reset");
        rchk(OFF_WKCTL, RST_ZERO, "wake ctl reset");
        rd_reg(8'h10);
        check(rd, RST_ZERO, "unmapped data");
        check({30'h0, rs}, {30'h0, RESP_SLVERR}, "unmapped read resp");
        wr(8'h10, 32'hffff_ffff, RESP_SLVERR);
        // writing ones must not disturb the live indicators
        wr(OFF_BUFSTS, 32'hffff_ffff, RESP_OKAY);
        rchk(OFF_BUFSTS, RST_BUFSTS, "status after write");
    endtask

    // every combination of the four buffer indicators
    task automatic t_levels;
        logic [3:0] i;
        for (int k = 0; k < 16; k++) begin
            i = k[3:0];
            @(posedge aclk);
            tx_buffer_full <= i[3];
            tx_buffer_empty <= i[2];
            rx_buffer_full <= i[1];
            rx_buffer_empty <= i[0];
            // indicators follow the live buffer levels
            rchk(OFF_BUFSTS, {22'h0, i[3:2], 6'h0, i[1:0]}, "levels");
        end
        @(posedge aclk);
        {tx_buffer_full, tx_buffer_empty} <= 2'h1;
        {rx_buffer_full, rx_buffer_empty} <= 2'h1;
    endtask

    task automatic t_underrun;
        wr(OFF_BUFCTL, 32'h0000_0040, RESP_OKAY);
        wr(OFF_IRQMSK, RST_ZERO, RESP_OKAY);
        @(posedge aclk);
        slave_tx_slot <= 1'h1;
        @(posedge aclk);
        slave_tx_slot <= 1'h0;
        repeat (3) @(posedge aclk);
        #1;
        cb(underrun_irq, 1'h1, "underrun request");
        cb(irq, 1'h0, "irq masked");
        rchk(OFF_BUFSTS, 32'h0000_0901, "underrun flag");
        wr(OFF_IRQMSK, 32'h0000_0800, RESP_OKAY);
        rchk(OFF_IRQMSK, 32'h0000_0800, "mask readback");
        repeat (3) @(posedge aclk);
        #1;
        cb(irq, 1'h1, "irq unmasked");
        wr(OFF_BUFSTS, 32'h0000_0800, RESP_OKAY);
        rchk(OFF_BUFSTS, RST_BUFSTS, "underrun cleared");
        cb(underrun_irq, 1'h0, "underrun dropped");
        cb(irq, 1'h0, "irq dropped");
    endtask

    task automatic t_overrun;
        wr(OFF_BUFCTL, 32'h0000_4000, RESP_OKAY);
        wr(OFF_IRQMSK, 32'h0000_0008, RESP_OKAY);
        // a reception into a buffer with room is no overrun
        @(posedge aclk);
        rx_done <= 1'h1;
        @(posedge aclk);
        rx_done <= 1'h0;
        rchk(OFF_BUFSTS, RST_BUFSTS, "no overrun");
        @(posedge aclk);
        {rx_buffer_full, rx_buffer_empty} <= 2'h2;
        @(posedge aclk);
        rx_done <= 1'h1;
        @(posedge aclk);
        rx_done <= 1'h0;
        rchk(OFF_BUFSTS, 32'h0000_010a, "overrun flag");
        cb(overrun_irq, 1'h1, "overrun request");
        cb(irq, 1'h1, "irq overrun");
        wr(OFF_BUFCTL, RST_ZERO, RESP_OKAY);
        rchk(OFF_BUFSTS, 32'h0000_010a, "flag stays");
        cb(overrun_irq, 1'h0, "overrun disabled");
        wr(OFF_BUFSTS, 32'h0000_0008, RESP_OKAY);
        rchk(OFF_BUFSTS, 32'h0000_0102, "overrun cleared");
        {rx_buffer_full, rx_buffer_empty} <= 2'h1;
    endtask

    task automatic t_power;
        step(4'h9);
        step(4'h0);
        cb(xfer_abort, 1'h1, "abort");
        cb(powerdown, 1'h1, "power-down");
        step(4'h4);
        cb(xfer_abort, 1'h0, "abort one cycle");
        step(4'h0);
        step(4'h0);
        cb(powerdown, 1'h1, "no wake disabled");
        wr(OFF_WKCTL, 32'h0000_0001, RESP_OKAY);
        step(4'h4);
        step(4'h0);
        cb(wake_req, 1'h1, "wake on toggle");
        cb(powerdown, 1'h0, "awake");
        rchk(OFF_WKSTS, 32'h0000_0001, "wake flag");
        wr(OFF_WKSTS, 32'h0000_0001, RESP_OKAY);
        rchk(OFF_WKSTS, RST_ZERO, "wake flag cleared");
        wr(OFF_WKCTL, 32'h0000_0003, RESP_OKAY);
        step(4'h8);
        step(4'h0);
        cb(powerdown, 1'h1, "idle power-down");
        cb(xfer_abort, 1'h0, "no abort idle");
        step(4'h4);
        step(4'h0);
        step(4'h0);
        cb(powerdown, 1'h1, "toggle ignored");
        step(4'h2);
        step(4'h0);
        cb(wake_req, 1'h1, "wake on match");
        wr(OFF_WKCTL, 32'h0000_0004, RESP_OKAY);
        step(4'h9);
        step(4'h1);
        cb(idle_mode, 1'h1, "idle entered");
        cb(powerdown, 1'h0, "no power-down");
        cb(xfer_abort, 1'h0, "transfer kept");
        step(4'h1);
        step(4'h0);
        step(4'h0);
        cb(idle_mode, 1'h0, "idle left");
    endtask

    // free-running clock, 20 ns period
    initial begin
        aclk = 1'h0;
        forever #10 aclk = ~aclk;
    end

    // hang guard: the whole run needs a few hundred cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run;
        end
    end

    // reset for four cycles, then the scenarios in turn
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
        {awaddr, araddr, wdata, wstrb} = 52'h0;
        {tx_buffer_full, tx_buffer_empty} = 2'h1;
        {rx_buffer_full, rx_buffer_empty} = 2'h1;
        {rx_done, slave_tx_slot, xfer_active, pd_request} = 4'h0;
        {data_toggle, addr_match} = 2'h0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'h1;
        t_reset;
        t_levels;
        t_underrun;
        t_overrun;
        t_power;
        complete_run;
    end
endmodule
